/* File: pkg/ffo_defs.svh */
// Constants for the FIFO flag and offset programming block
`ifndef FFO_DEFS_SVH
`define FFO_DEFS_SVH
// ==========================================================
// Geometry
`define FFO_DEPTH 16384
`define FFO_WIDTH 40
// ==========================================================
// Register byte offsets and AXI response codes
`define FFO_ADDR_EMPTY_OFS 4'h0
`define FFO_ADDR_FULL_OFS 4'h4
`define FFO_ADDR_STATUS 4'h8
`define FFO_ADDR_COUNT 4'hc
`define FFO_RESP_OKAY 2'h0
`define FFO_RESP_SLVERR 2'h2
// ==========================================================
// Default offsets picked by the two select pins at reset
`define FFO_OFS_HH 32'h000000ff
`define FFO_OFS_LH 32'h0000007f
`define FFO_OFS_HL 32'h0000003f
`define FFO_OFS_LL 32'h00000007
// Flag levels with an empty FIFO (field order of the flag struct)
`define FFO_FLAGS_RST 6'h16
// ==========================================================
// Timing
`define FFO_CLK_HZ 50000000
`define FFO_SER_MAX_HZ 10000000
`define FFO_SER_MIN_CYC ((`FFO_CLK_HZ + `FFO_SER_MAX_HZ - 1) / `FFO_SER_MAX_HZ)
`endif

/* File: pkg/ffo_pkg.sv */
// Types shared by the FIFO flag and offset programming block
package ffo_pkg;
    typedef enum logic {
        FFO_MODE_STD = 1'b0,
        FFO_MODE_FALL_THROUGH_SELECT = 1'b1
    } ffo_mode_type;

    typedef enum logic [1:0] {
        FFO_SER_IDLE = 2'h0,
        FFO_SER_LOAD = 2'h1,
        FFO_SER_READ = 2'h3
    } ffo_ser_state_type;

    typedef struct packed {
        logic in_space_flag;
        logic near_full_flag;
        logic near_empty_flag;
        logic out_valid_n;
        logic full_flag;
        logic empty_flag;
    } ffo_flags_type;

    typedef struct packed {
        logic [21:0] zero;
        ffo_flags_type flags;
        ffo_ser_state_type ser_state;
        logic load_partial;
        logic fall_through;
    } ffo_status_type;
endpackage

/* File: hdl/ffo_fifo_flags.sv */
// FIFO store with status flags, default offsets and serial offset programming
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "ffo_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - First write into empty FIFO drives valid low
// - Fall-through near-empty rises at n+2 words
// - Fall-through near-full falls at depth+1-m words
// - Fall-through capacity is depth plus one
// - Valid rises after last word; reads blocked
// - Read request ignored while FIFO empty
// - Valid three stages, space flag two stages
// - Fall-through only with single data rate
// - Fall-through flags follow the word count
// - Standard flags follow the word count
// - Select pins load default offsets at reset
// - Serial load shifts one bit per edge
// - Stream: empty offset LSB first, full MSB last
// - Near flags valid only after complete set
// - Readback drives next bit each serial edge
// - Each readback restarts at the first bit
// - Offsets range zero to depth minus one
// - Select pin at reset picks the mode
// - First word falls through in three edges
module ffo_fifo_flags #(
    parameter int DEPTH = `FFO_DEPTH,
    parameter int WIDTH = `FFO_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_fall_through_select,
    input wire logic i_ddr_select,
    input wire logic i_default_offset_sel_hi,
    input wire logic i_default_offset_sel_lo,
    input wire logic i_wr_req_n,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_rd_req_n,
    output logic [WIDTH-1:0] o_rd_data,
    output ffo_pkg::ffo_flags_type o_flags,
    input wire logic i_ser_clk,
    input wire logic i_ser_load_en_n,
    input wire logic i_ser_readback_en_n,
    input wire logic i_ser_in,
    output logic o_ser_out,
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int OW = 2 * AW;
    localparam int BW = $clog2(OW);
    localparam logic [BW-1:0] LASTB = BW'(OW - 1);

    // Offsets wider than the pointers could not be reached
    if (DEPTH < 256 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("DEPTH must be a power of two of at least 256");
    end

    // ==========================================================
    // Helpers
    function automatic logic [AW-1:0] default_ofs(input logic hi, input logic lo);
        logic [31:0] v;
        v = `FFO_OFS_LL;
        case ({hi, lo})
            2'h3: v = `FFO_OFS_HH;
            2'h1: v = `FFO_OFS_LH;
            2'h2: v = `FFO_OFS_HL;
            default: v = `FFO_OFS_LL;
        endcase
        return v[AW-1:0];
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Storage and pointers
    ffo_pkg::ffo_mode_type mode;
    logic fall_through_select;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr;
    logic [CW-1:0] mem_cnt, total, next_mem_cnt, next_total;
    logic out_valid, next_out_valid, wr_fire, pop, rd_take;
    logic [AW-1:0] empty_ofs, full_ofs;

    assign fall_through_select = (mode == ffo_pkg::FFO_MODE_FALL_THROUGH_SELECT);
    assign total = mem_cnt + CW'(out_valid);

    always_comb begin
        wr_fire = !i_wr_req_n && (mem_cnt != CW'(DEPTH));
        if (fall_through_select) begin
            // Output register refills itself, no request needed
            rd_take = !i_rd_req_n && out_valid;
            pop = (mem_cnt != '0) && (!out_valid || rd_take);
            next_out_valid = pop || (out_valid && !rd_take);
        end else begin
            rd_take = 1'b0;
            pop = !i_rd_req_n && (mem_cnt != '0);
            next_out_valid = 1'b0;
        end
        next_mem_cnt = mem_cnt + CW'(wr_fire) - CW'(pop);
        next_total = next_mem_cnt + CW'(next_out_valid);
    end

    // Mode is caught only while reset is held
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode <= ffo_pkg::ffo_mode_type'(i_fall_through_select && !i_ddr_select);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            mem_cnt <= '0;
            out_valid <= 1'b0;
        end else if (i_ce) begin
            wr_ptr <= wr_ptr + AW'(wr_fire);
            rd_ptr <= rd_ptr + AW'(pop);
            mem_cnt <= next_mem_cnt;
            out_valid <= next_out_valid;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst && i_ce && wr_fire) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (i_ce && pop) begin
            o_rd_data <= mem[rd_ptr];
        end
    end

    // ==========================================================
    // Status flags
    ffo_pkg::ffo_flags_type raw, s1, s2;
    logic ov_s3;
    logic [BW-1:0] bit_cnt;

    always_comb begin
        raw.in_space_flag = fall_through_select && (next_total == CW'(DEPTH + 1));
        raw.near_full_flag = !(next_total >= CW'(DEPTH) + CW'(fall_through_select) - CW'(full_ofs));
        raw.near_empty_flag = next_total >= CW'(empty_ofs) + (fall_through_select ? CW'(2'h2) : CW'(2'h1));
        raw.out_valid_n = !next_out_valid;
        raw.full_flag = next_total < CW'(DEPTH);
        raw.empty_flag = next_total != '0;
    end

    // Flag chain runs on the single clock that serves both sides
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1 <= `FFO_FLAGS_RST;
            s2 <= `FFO_FLAGS_RST;
            ov_s3 <= 1'b1;
        end else if (i_ce) begin
            s1 <= raw;
            if (bit_cnt != '0) begin
                // Partial offset set: keep the last trusted levels
                s1.near_full_flag <= s1.near_full_flag;
                s1.near_empty_flag <= s1.near_empty_flag;
            end
            s2 <= s1;
            ov_s3 <= s2.out_valid_n;
        end
    end

    assign o_flags = '{in_space_flag: s2.in_space_flag, near_full_flag: s1.near_full_flag,
                       near_empty_flag: s1.near_empty_flag, out_valid_n: ov_s3,
                       full_flag: s2.full_flag, empty_flag: s2.empty_flag};

    // ==========================================================
    // Serial offset port
    ffo_pkg::ffo_ser_state_type ser_state, next_ser_state;
    logic sclk_q, ser_rise;
    logic [OW-1:0] shadow, commit_word, ofs_word;
    logic [BW-1:0] rb_idx;
    logic commit;

    assign ser_rise = i_ser_clk && !sclk_q;
    assign commit_word = {i_ser_in, shadow[OW-1:1]};
    assign ofs_word = {full_ofs, empty_ofs};
    assign commit = (next_ser_state == ffo_pkg::FFO_SER_LOAD) && ser_rise && bit_cnt == LASTB;

    always_comb begin
        case ({i_ser_load_en_n, i_ser_readback_en_n})
            2'h0, 2'h1: next_ser_state = ffo_pkg::FFO_SER_LOAD;
            2'h2: next_ser_state = ffo_pkg::FFO_SER_READ;
            default: next_ser_state = ffo_pkg::FFO_SER_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            ser_state <= ffo_pkg::FFO_SER_IDLE;
            shadow <= '0;
            bit_cnt <= '0;
        end else if (i_ce) begin
            sclk_q <= i_ser_clk;
            ser_state <= next_ser_state;
            if (next_ser_state != ffo_pkg::FFO_SER_LOAD) begin
                bit_cnt <= '0;
            end else if (ser_rise) begin
                shadow <= commit_word;
                bit_cnt <= (bit_cnt == LASTB) ? '0 : bit_cnt + BW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rb_idx <= '0;
            o_ser_out <= 1'b0;
        end else if (i_ce) begin
            if (next_ser_state != ffo_pkg::FFO_SER_READ) begin
                rb_idx <= '0;
            end else if (ser_rise) begin
                o_ser_out <= ofs_word[rb_idx];
                rb_idx <= (rb_idx == LASTB) ? '0 : rb_idx + BW'(1);
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_hold, w_hold, do_write;
    logic [3:0] aw_addr_q, w_strb_q;
    logic [31:0] w_data_q, wr_empty, wr_full;
    ffo_pkg::ffo_status_type status;

    assign o_awready = i_ce && !aw_hold && !o_bvalid;
    assign o_wready = i_ce && !w_hold && !o_bvalid;
    assign o_arready = i_ce && !o_rvalid;
    assign do_write = aw_hold && w_hold && !o_bvalid;
    assign wr_empty = wmerge(32'(empty_ofs), w_data_q, w_strb_q);
    assign wr_full = wmerge(32'(full_ofs), w_data_q, w_strb_q);
    assign status = '{zero: '0, flags: o_flags, ser_state: ser_state,
                      load_partial: bit_cnt != '0, fall_through: fall_through_select};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            o_bvalid <= 1'b0;
            o_bresp <= `FFO_RESP_OKAY;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_hold <= 1'b1;
                aw_addr_q <= {i_awaddr[3:2], 2'h0};
            end
            if (i_wvalid && o_wready) begin
                w_hold <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_addr_q == `FFO_ADDR_EMPTY_OFS || aw_addr_q == `FFO_ADDR_FULL_OFS)
                           ? `FFO_RESP_OKAY : `FFO_RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= `FFO_RESP_OKAY;
        end else if (i_ce) begin
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp <= `FFO_RESP_OKAY;
                case ({i_araddr[3:2], 2'h0})
                    `FFO_ADDR_EMPTY_OFS: o_rdata <= 32'(empty_ofs);
                    `FFO_ADDR_FULL_OFS: o_rdata <= 32'(full_ofs);
                    `FFO_ADDR_STATUS: o_rdata <= status;
                    `FFO_ADDR_COUNT: o_rdata <= 32'(total);
                    default: begin
                        o_rdata <= '0;
                        o_rresp <= `FFO_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Offset registers
    // Width of AW bits keeps every offset within zero to depth-1
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            empty_ofs <= default_ofs(i_default_offset_sel_hi, i_default_offset_sel_lo);
            full_ofs <= default_ofs(i_default_offset_sel_hi, i_default_offset_sel_lo);
        end else if (i_ce) begin
            if (commit) begin
                {full_ofs, empty_ofs} <= commit_word;
            end else if (do_write && aw_addr_q == `FFO_ADDR_EMPTY_OFS) begin
                empty_ofs <= wr_empty[AW-1:0];
            end else if (do_write && aw_addr_q == `FFO_ADDR_FULL_OFS) begin
                full_ofs <= wr_full[AW-1:0];
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ov_three_stage_a: assert property (
        i_ce && next_out_valid ##1 i_ce ##1 i_ce |=> !o_flags.out_valid_n)
        else $error("valid flag not low three edges after word loaded");
    ir_two_stage_a: assert property (
        i_ce && fall_through_select && next_total == CW'(DEPTH + 1) ##1 i_ce |=> o_flags.in_space_flag)
        else $error("space flag not high two edges after full");
    capacity_a: assert property (
        total <= CW'(DEPTH) + CW'(fall_through_select))
        else $error("word count beyond capacity");
    empty_read_a: assert property (
        i_ce && !i_rd_req_n && total == '0 |=> $stable(rd_ptr) && $stable(o_rd_data))
        else $error("read from empty FIFO moved state");
    std_empty_a: assert property (
        i_ce && !fall_through_select && next_total == '0 ##1 i_ce |=> !o_flags.empty_flag)
        else $error("empty flag not low at zero words");
    ft_near_empty_a: assert property (
        i_ce && fall_through_select && bit_cnt == '0 && next_total >= CW'(empty_ofs) + CW'(2'h2)
        |=> o_flags.near_empty_flag)
        else $error("near-empty not high at n+2 words");
    ft_near_full_a: assert property (
        i_ce && fall_through_select && bit_cnt == '0 && next_total >= CW'(DEPTH + 1) - CW'(full_ofs)
        |=> !o_flags.near_full_flag)
        else $error("near-full not low at depth+1-m words");
    ser_commit_a: assert property (
        i_ce && commit |=> {full_ofs, empty_ofs} == $past(commit_word))
        else $error("serial offset set not committed");
    rb_first_bit_a: assert property (
        i_ce && ser_rise && next_ser_state == ffo_pkg::FFO_SER_READ && rb_idx == '0
        |=> o_ser_out == $past(empty_ofs[0]))
        else $error("readback did not start with empty offset LSB");
    rb_restart_a: assert property (
        i_ce && i_ser_readback_en_n |=> rb_idx == '0)
        else $error("readback position not restarted");
    reset_dflt_a: assert property (
        $fell(i_rst) |-> empty_ofs == full_ofs && empty_ofs == default_ofs(
            $past(i_default_offset_sel_hi), $past(i_default_offset_sel_lo)))
        else $error("default offsets not loaded at reset");
    reset_mode_a: assert property (
        $fell(i_rst) |-> fall_through_select == ($past(i_fall_through_select) && !$past(i_ddr_select)))
        else $error("mode not taken from select pins");

    ft_full_c: cover property (fall_through_select && total == CW'(DEPTH + 1));
    ser_commit_c: cover property (i_ce && commit);
    std_read_c: cover property (!fall_through_select && i_ce && pop ##1 total == '0);
    readback_c: cover property (i_ce && ser_rise && rb_idx == LASTB);
endmodule

`default_nettype wire

/* File: tb/ffo_far_side.sv */
// Far-side model: writer, reader and serial offset master
`include "ffo_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ffo_far_side #(
    parameter int OBITS = 14
) (
    input wire logic i_clk,
    output logic o_wr_req_n,
    output logic [`FFO_WIDTH-1:0] o_wr_data,
    output logic o_rd_req_n,
    output logic o_ser_clk,
    output logic o_ser_load_en_n,
    output logic o_ser_readback_en_n,
    output logic o_ser_in,
    input wire logic i_ser_out
);
    initial begin
        o_wr_req_n = 1'b1;
        o_wr_data = '0;
        o_rd_req_n = 1'b1;
        o_ser_clk = 1'b0;
        o_ser_load_en_n = 1'b1;
        o_ser_readback_en_n = 1'b1;
        o_ser_in = 1'b0;
    end
    // Request and word held across the whole capturing edge
    task automatic write_words(input int n, input logic [`FFO_WIDTH-1:0] base);
        for (int i = 0; i < n; i++) begin
            o_wr_req_n <= 1'b0;
            o_wr_data <= base + `FFO_WIDTH'(i);
            @(posedge i_clk);
        end
        o_wr_req_n <= 1'b1;
        o_wr_data <= ~o_wr_data;
    endtask
    task automatic read_words(input int n);
        o_rd_req_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_rd_req_n <= 1'b1;
    endtask
    // Six system cycles per serial period keeps the rate under the ceiling
    task automatic ser_bit();
        repeat (3) @(posedge i_clk);
        o_ser_clk <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask
    // Shorter counts leave a partial set that must not commit
    task automatic ser_load(input logic [2*OBITS-1:0] bits, input int nbits);
        o_ser_load_en_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_ser_in <= bits[i];
            ser_bit();
            o_ser_clk <= 1'b0;
        end
        repeat (3) @(posedge i_clk);
        o_ser_load_en_n <= 1'b1;
        o_ser_in <= ~o_ser_in;
        // Release must be seen for an edge, or a next set would run on
        @(posedge i_clk);
    endtask
    task automatic ser_read(input int nbits, output logic [2*OBITS-1:0] bits);
        bits = '0;
        o_ser_readback_en_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            ser_bit();
            bits[i] = i_ser_out;
            o_ser_clk <= 1'b0;
        end
        repeat (3) @(posedge i_clk);
        o_ser_readback_en_n <= 1'b1;
        // A seen release is what restarts the next readback
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/ffo_fifo_flags_tb.sv */
// Self-checking bench for the FIFO flag and offset block
`include "ffo_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ffo_fifo_flags_tb;
    typedef struct packed {
        int n;
        logic [3:0] f;
    } ffo_row_type;
    localparam int CAP = `FFO_DEPTH + 1;
    localparam logic [39:0] BASE = 40'h5a00000000;
    logic clk = 1'b0, rst = 1'b1, ft = 1'b1, ddr = 1'b0, shi = 1'b0, slo = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [39:0] rd_data, wr_d;
    ffo_pkg::ffo_flags_type flags;
    logic ser_out, awready, wready, bvalid, arready, rvalid, wr_n, rd_n, sclk, sld_n, srb_n, sin;
    logic [1:0] bresp, rresp;
    int err_total = 0, n_compared = 0, cyc = 0;
    ffo_fifo_flags ffo_fifo_flags_inst (.i_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_fall_through_select(ft), .i_ddr_select(ddr), .i_default_offset_sel_hi(shi),
        .i_default_offset_sel_lo(slo), .i_wr_req_n(wr_n), .i_wr_data(wr_d), .i_rd_req_n(rd_n),
        .o_rd_data(rd_data), .o_flags(flags), .i_ser_clk(sclk), .i_ser_load_en_n(sld_n),
        .i_ser_readback_en_n(srb_n), .i_ser_in(sin), .o_ser_out(ser_out), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
    ffo_far_side ffo_far_side_inst (.i_clk(clk), .o_wr_req_n(wr_n), .o_wr_data(wr_d),
        .o_rd_req_n(rd_n), .o_ser_clk(sclk), .o_ser_load_en_n(sld_n),
        .o_ser_readback_en_n(srb_n), .o_ser_in(sin), .i_ser_out(ser_out));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole fill and drain at full depth fits well inside this ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic miss(input string what);
        err_total++;
        $display("[FAIL] %0t %s", $time, what);
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) miss(what);
    endtask
    task automatic chk_flags(input logic [5:0] mask, input logic [5:0] exp);
        n_compared++;
        if ((flags & mask) !== exp) miss("flag levels");
    endtask
    task automatic chk_data(input logic [39:0] exp);
        n_compared++;
        if (rd_data !== exp) miss("read data");
    endtask
    task automatic do_reset(input logic f, input logic d, input logic h, input logic l);
        ft <= f;
        ddr <= d;
        shi <= h;
        slo <= l;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [27:0] sb;
        logic [31:0] dflt [4];
        ffo_row_type rows [8];
        int cur;
        dflt = '{`FFO_OFS_LL, `FFO_OFS_LH, `FFO_OFS_HL, `FFO_OFS_HH};
        rows = '{'{1, 4'h4}, '{8, 4'h4}, '{9, 4'h6}, '{CAP - 8, 4'h6}, '{CAP - 7, 4'h2},
            '{CAP - 1, 4'h2}, '{CAP, 4'ha}, '{CAP + 1, 4'ha}};
        // Select pins, mode pins and serial readback of the defaults
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b1, i[0], i[1], i[0]);
            axi_read(`FFO_ADDR_EMPTY_OFS, v);
            chk32(v, dflt[i], "empty offset default");
            axi_read(`FFO_ADDR_FULL_OFS, v);
            chk32(v, dflt[i], "full offset default");
            axi_read(`FFO_ADDR_STATUS, v);
            chk32(v & 32'h1, {31'h0, ~i[0]}, "timing mode");
            ffo_far_side_inst.ser_read(28, sb);
            chk32({4'h0, sb}, {4'h0, dflt[i][13:0], dflt[i][13:0]}, "readback");
        end
        // Fall-through fill to capacity with offsets of seven, one refused write at the end
        do_reset(1'b1, 1'b0, 1'b0, 1'b0);
        cur = 0;
        foreach (rows[k]) begin
            ffo_far_side_inst.write_words(rows[k].n - cur, BASE + 40'(cur));
            cur = rows[k].n;
            repeat (6) @(posedge clk);
            chk_flags(6'h3c, {rows[k].f, 2'b00});
            axi_read(`FFO_ADDR_COUNT, v);
            chk32(v, (cur > CAP) ? 32'(CAP) : 32'(cur), "word count");
            if (cur == 1) chk_data(BASE);
        end
        ffo_far_side_inst.read_words(CAP + 10);
        repeat (6) @(posedge clk);
        chk_flags(6'h3c, 6'h14);
        chk_data(BASE + 40'(CAP - 1));
        axi_read(`FFO_ADDR_COUNT, v);
        chk32(v, 32'h0, "count after drain");
        // Standard mode with serial offsets of two (empty) and the range top (full), then an aborted load
        do_reset(1'b0, 1'b0, 1'b1, 1'b1);
        sb = {14'd16383, 14'd2};
        ffo_far_side_inst.ser_load(sb, 28);
        ffo_far_side_inst.ser_load(28'h0, 10);
        axi_read(`FFO_ADDR_EMPTY_OFS, v);
        chk32(v, 32'h2, "empty offset serial");
        axi_read(`FFO_ADDR_FULL_OFS, v);
        chk32(v, 32'h3fff, "full offset serial");
        ffo_far_side_inst.ser_read(5, v[27:0]);
        ffo_far_side_inst.ser_read(28, v[27:0]);
        chk32({4'h0, v[27:0]}, {4'h0, sb}, "readback restart");
        chk_flags(6'h1b, 6'h12);
        ffo_far_side_inst.write_words(2, BASE);
        repeat (6) @(posedge clk);
        chk_flags(6'h1b, 6'h03);
        ffo_far_side_inst.write_words(1, BASE + 40'h2);
        repeat (6) @(posedge clk);
        chk_flags(6'h1b, 6'h0b);
        ffo_far_side_inst.read_words(1);
        repeat (6) @(posedge clk);
        chk_flags(6'h1b, 6'h03);
        chk_data(BASE);
        axi_write(`FFO_ADDR_STATUS, 32'h1, r);
        chk32({30'h0, r}, {30'h0, `FFO_RESP_SLVERR}, "status write");
        axi_write(`FFO_ADDR_EMPTY_OFS, 32'h100, r);
        chk32({30'h0, r}, {30'h0, `FFO_RESP_OKAY}, "offset write");
        axi_read(`FFO_ADDR_EMPTY_OFS, v);
        chk32(v, 32'h100, "offset readback");
        chk32({30'h0, rresp}, {30'h0, `FFO_RESP_OKAY}, "read response");
        print_verdict();
    end
endmodule
`default_nettype wire
